// file: rtl/sarp_pkg.sv
// constants and types shared by the converter control and readout logic
// Operation
// - busy output is high exactly while a conversion runs, low otherwise.
// - byte select high puts D[7:0] on bus high byte, low byte all ones.
// - convert strobe falling edge ends sampling, enters hold, starts conversion.
// - chip select falling edge starts acquisition when no conversion runs.
// - reset pin low aborts conversion and clears output latches, chip select ignored.
// - with chip select low, read strobe enables the latest completed result.
// - conversions are timed internally, 500 to 650 ns, no external clock.
// - strobe or chip select falling edge 70 to 500 ns into conversion aborts it.
// - previous result stays valid during conversion; new result by max time plus 20 ns.
// - results are two's complement, 7FFF positive and 8000 negative full scale.
// - bus is driven only while chip select and read strobe are both low.
package sarp_pkg;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 600;
  localparam int ABORT_MIN_NS = 70;
  localparam int ABORT_MAX_NS = 500;
  localparam int CNT_W = 7;
  // conversion length rounds down so it never exceeds the 650 ns ceiling
  localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'(CONV_TIME_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_TIME_NS / CLK_PERIOD_NS - 1);
  localparam logic [CNT_W-1:0] ABORT_MIN_CYC =
    CNT_W'((ABORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ABORT_MAX_CYC = CNT_W'(ABORT_MAX_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_FILL = 8'hFF;
  // pin order inside the synchroniser vector
  localparam int PIN_N = 5;
  localparam int PIN_RST = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_CONV = 2;
  localparam int PIN_RD = 3;
  localparam int PIN_BYTE = 4;
  localparam logic [PIN_N-1:0] PIN_IDLE = 5'h0F;
  typedef enum logic {ST_ACQ, ST_CONV} sarp_state_t;
endpackage

// file: rtl/sarp_pins_if.sv
// synchronised pin levels and falling-edge pulses between synchroniser and control
interface sarp_pins_if import sarp_pkg::*;;
  logic [PIN_N-1:0] level;
  logic [PIN_N-1:0] fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface

// file: rtl/sarp_pin_sync.sv
// two-flop synchronisers with falling-edge detection for the host pins
module sarp_pin_sync import sarp_pkg::*; (
  input wire logic ref_clk_in,          // core clock
  input wire logic reset_in,            // async reset, active high
  input wire logic [PIN_N-1:0] pins_in, // raw host pins
  sarp_pins_if.src pins                 // synchronised levels and edges
);
  genvar i;
  generate
    for (i = 0; i < PIN_N; i++) begin : g_pin
      logic meta_r, sync_r, prev_r;
      always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
          meta_r <= PIN_IDLE[i];
          sync_r <= PIN_IDLE[i];
          prev_r <= PIN_IDLE[i];
        end else begin
          meta_r <= pins_in[i];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end
      // edges come from the second and third flops, never the first
      assign pins.level[i] = sync_r;
      assign pins.fall[i] = prev_r & ~sync_r;
    end
  endgenerate
endmodule // sarp_pin_sync

// file: rtl/sarp_adc_readout.sv
// conversion sequencing, abort handling and parallel result readout
module sarp_adc_readout import sarp_pkg::*; (
  input wire logic ref_clk_in,                        // 125 MHz core clock
  input wire logic reset_in,                          // async system reset, active high
  input wire logic reset_n_in,                        // reset pin, active low
  input wire logic chip_select_n_in,                  // chip select, active low
  input wire logic convert_strobe_n_in,               // convert strobe, active low
  input wire logic read_n_in,                         // read strobe, active low
  input wire logic byte_sel_in,                       // byte select, high = low byte
  input wire logic [DATA_W-1:0] sample_code_in,       // code from the sar array
  output logic busy_out,                              // conversion in progress
  output logic sample_track_out,                      // input sampling active
  output logic [DATA_W-1:0] parallel_data_bus_out,    // bus data
  output logic parallel_data_bus_oe_out               // bus drive enable
);
  sarp_pins_if pins ();

  sarp_pin_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in (reset_in),
    .pins_in ({byte_sel_in, read_n_in, convert_strobe_n_in, chip_select_n_in, reset_n_in}),
    .pins (pins.src)
  );

  logic cs_n, rd_n, byte_sel, rst_pin_n, cs_fall, cv_fall;
  assign cs_n = pins.level[PIN_CS];
  assign rd_n = pins.level[PIN_RD];
  assign byte_sel = pins.level[PIN_BYTE];
  assign rst_pin_n = pins.level[PIN_RST];
  assign cs_fall = pins.fall[PIN_CS];
  assign cv_fall = pins.fall[PIN_CONV];

  sarp_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [DATA_W-1:0] result_r, result_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic busy_r, busy_nxt;
  logic track_r, track_nxt;
  logic oe_r, oe_nxt;
  logic in_reset_r, in_reset_nxt;
  logic conv_start, abort_hit, conv_done;

  // strobe needs chip select low at its falling edge
  assign conv_start = (state_r == ST_ACQ) && cv_fall && !cs_n && rst_pin_n;
  // edges outside the window are ignored rather than treated as aborts
  assign abort_hit = (state_r == ST_CONV) && rst_pin_n && ((cv_fall && !cs_n) || cs_fall)
                     && (cnt_r >= ABORT_MIN_CYC) && (cnt_r <= ABORT_MAX_CYC);
  assign conv_done = (state_r == ST_CONV) && rst_pin_n && !abort_hit
                     && (cnt_r == CONV_LAST);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    result_nxt = result_r;
    track_nxt = track_r;
    in_reset_nxt = !rst_pin_n;
    if (!rst_pin_n) begin
      // pin reset works regardless of chip select
      state_nxt = ST_ACQ;
      cnt_nxt = CNT_ZERO;
      result_nxt = RESULT_RESET;
      track_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_ACQ: begin
          if (in_reset_r || cs_fall) begin
            track_nxt = 1'b1;
          end
          if (conv_start) begin
            state_nxt = ST_CONV;
            cnt_nxt = CNT_ZERO;
            track_nxt = 1'b0;
          end
        end
        ST_CONV: begin
          cnt_nxt = cnt_r + CNT_ONE;
          if (abort_hit) begin
            // self-clearing abort behaves like the reset pin
            state_nxt = ST_ACQ;
            cnt_nxt = CNT_ZERO;
            result_nxt = RESULT_RESET;
            track_nxt = 1'b1;
          end else if (conv_done) begin
            state_nxt = ST_ACQ;
            cnt_nxt = CNT_ZERO;
            // two's complement code passes through unaltered
            result_nxt = sample_code_in;
            // with chip select high, sampling waits for its falling edge
            track_nxt = !cs_n;
          end
        end
        default: begin
          state_nxt = ST_ACQ;
          cnt_nxt = CNT_ZERO;
        end
      endcase
    end
  end

  always_comb begin
    busy_nxt = (state_nxt == ST_CONV);
    oe_nxt = !cs_n && !rd_n;
    if (byte_sel) begin
      data_nxt = {result_r[BYTE_W-1:0], BYTE_FILL};
    end else begin
      data_nxt = result_r;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= ST_ACQ;
      cnt_r <= CNT_ZERO;
      result_r <= RESULT_RESET;
      track_r <= 1'b0;
      in_reset_r <= 1'b1;
      busy_r <= 1'b0;
      oe_r <= 1'b0;
      data_r <= RESULT_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      result_r <= result_nxt;
      track_r <= track_nxt;
      in_reset_r <= in_reset_nxt;
      busy_r <= busy_nxt;
      oe_r <= oe_nxt;
      data_r <= data_nxt;
    end
  end

  assign busy_out = busy_r;
  assign sample_track_out = track_r;
  assign parallel_data_bus_out = data_r;
  assign parallel_data_bus_oe_out = oe_r;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_conv_end;
    conv_done ##1 !busy_out;
  endsequence

  sequence s_start;
    conv_start ##1 busy_out;
  endsequence

  property p_start_busy;
    conv_start |-> s_start;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy did not rise after conversion start");

  property p_conv_end;
    conv_done |-> s_conv_end;
  endproperty
  a_conv_end: assert property (p_conv_end)
    else $error("busy did not fall after conversion end");

  property p_conv_len;
    conv_done |-> cnt_r == CONV_LAST && busy_out;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  property p_busy_hold;
    s_start ##0 (rst_pin_n && !cv_fall && !cs_fall) [*8] |-> busy_out;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");

  property p_pin_reset;
    !rst_pin_n |=> result_r == RESULT_RESET && !busy_out;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("pin reset did not clear");

  property p_abort;
    abort_hit |=> !busy_out && result_r == RESULT_RESET;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort not taken");

  property p_no_early_abort;
    state_r == ST_CONV && rst_pin_n && cnt_r < ABORT_MIN_CYC |=> busy_out;
  endproperty
  a_no_early_abort: assert property (p_no_early_abort)
    else $error("conversion ended inside the guard time");

  property p_hold_prev;
    state_r == ST_CONV && rst_pin_n && !conv_done && !abort_hit |=> $stable(result_r);
  endproperty
  a_hold_prev: assert property (p_hold_prev)
    else $error("result changed during conversion");

  property p_result_load;
    conv_done |=> result_r == $past(sample_code_in);
  endproperty
  a_result_load: assert property (p_result_load)
    else $error("result not loaded from sar code");

  property p_byte_hi;
    byte_sel |=> parallel_data_bus_out == {$past(result_r[BYTE_W-1:0]), BYTE_FILL};
  endproperty
  a_byte_hi: assert property (p_byte_hi)
    else $error("byte mode bus wrong");

  property p_word;
    !byte_sel |=> parallel_data_bus_out == $past(result_r);
  endproperty
  a_word: assert property (p_word)
    else $error("word mode bus wrong");

  property p_drive;
    (cs_n || rd_n) |=> !parallel_data_bus_oe_out;
  endproperty
  a_drive: assert property (p_drive)
    else $error("bus driven outside cs and read");

  property p_drive_on;
    (!cs_n && !rd_n) |=> parallel_data_bus_oe_out;
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("bus not driven during a read");

  property p_track;
    state_r == ST_ACQ && rst_pin_n && cs_fall && !conv_start |=> sample_track_out;
  endproperty
  a_track: assert property (p_track)
    else $error("acquisition not started on chip select");
endmodule // sarp_adc_readout

// file: verification/sarp_host_model.sv
// host controller model that drives the converter's strobe, select and read pins
module sarp_host_model import sarp_pkg::*; (
  input wire logic clk_in, // core clock
  input wire logic busy_in, // conversion in progress
  input wire logic [DATA_W-1:0] bus_in, // bus data
  input wire logic oe_in, // bus drive enable
  output logic cs_n_out, // chip select, active low
  output logic conv_n_out, // convert strobe, active low
  output logic rd_n_out, // read strobe, active low
  output logic byte_sel_out, // byte select
  output logic rst_n_out // reset pin, active low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n_out = 1'b0;
    conv_n_out = 1'b1;
    rd_n_out = 1'b1;
    byte_sel_out = 1'b0;
    rst_n_out = 1'b1;
  end

  // three cycles low keeps the strobe above its minimum width
  task automatic strobe();
    @(posedge clk_in) conv_n_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    conv_n_out <= 1'b1;
  endtask

  // quiet gap before the strobe so no read overlaps its edge
  task automatic start();
    repeat (8) @(posedge clk_in);
    cs_n_out <= 1'b0;
    strobe();
  endtask

  // counts busy cycles from the edge it is called at, so the first busy cycle
  // after a strobe is not lost; ends just after an edge
  task automatic run(input int cycles, output int n);
    n = 0;
    repeat (cycles) begin
      #1 if (busy_in === 1'b1) n++;
      @(posedge clk_in);
    end
    #1;
  endtask

  // called just after an edge, so the change lands off the sampling edge
  task automatic pins(input logic cs_n, input logic rst_n);
    cs_n_out <= cs_n;
    rst_n_out <= rst_n;
  endtask

  // the caller reads only once busy has fallen, except when probing held data
  task automatic read(input logic bsel, output logic [DATA_W-1:0] d, output logic on,
                      output logic off);
    @(posedge clk_in);
    byte_sel_out <= bsel;
    rd_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1 d = bus_in;
    on = oe_in;
    @(posedge clk_in) rd_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    #1 off = oe_in;
  endtask
endmodule // sarp_host_model

// file: verification/sar_adc_parallel_readout_tb.sv
// self-checking bench for the converter control and parallel readout
module sar_adc_parallel_readout_tb import sarp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [DATA_W-1:0] code; logic [DATA_W-1:0] word; logic [DATA_W-1:0] high;}
    sarp_row_t;
  logic ref_clk_in, reset_in, busy, track, oe, cs_n, conv_n, rd_n, byte_sel, rst_n;
  logic [DATA_W-1:0] sample_code_in, bus;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  sarp_row_t rows [4] = '{'{16'h7FFF, 16'h7FFF, 16'hFFFF}, '{16'h8000, 16'h8000, 16'h00FF},
    '{16'h0000, 16'h0000, 16'h00FF}, '{16'hA5C3, 16'hA5C3, 16'hC3FF}};

  sarp_adc_readout u_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .reset_n_in(rst_n),
    .chip_select_n_in(cs_n), .convert_strobe_n_in(conv_n), .read_n_in(rd_n),
    .byte_sel_in(byte_sel), .sample_code_in(sample_code_in), .busy_out(busy),
    .sample_track_out(track), .parallel_data_bus_out(bus), .parallel_data_bus_oe_out(oe));
  sarp_host_model u_host (.clk_in(ref_clk_in), .busy_in(busy), .bus_in(bus), .oe_in(oe),
    .cs_n_out(cs_n), .conv_n_out(conv_n), .rd_n_out(rd_n), .byte_sel_out(byte_sel),
    .rst_n_out(rst_n));

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // the whole run needs about 1800 cycles; a hang is cut off well beyond that
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    logic [DATA_W-1:0] d;
    logic on, off;
    int n, n2;
    reset_in = 1'b1;
    sample_code_in = 16'h0000;
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    #1 chk({15'h0000, busy}, 16'h0000, "busy after reset");
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge ref_clk_in) sample_code_in <= rows[i].code;
      u_host.start();
      u_host.run(100, n);
      chk(16'(n), 16'(CONV_CYC), "busy length");
      u_host.read(1'b0, d, on, off);
      chk(d, rows[i].word, "full word");
      chk({14'h0000, on, off}, 16'h0002, "drive enable");
      u_host.read(1'b1, d, on, off);
      chk(d, rows[i].high, "upper lanes");
      $display("row %0d done", i);
    end
    // a read in mid-conversion must still see the earlier result
    @(posedge ref_clk_in) sample_code_in <= 16'h1234;
    u_host.start();
    u_host.run(20, n);
    u_host.read(1'b0, d, on, off);
    chk(d, 16'hA5C3, "held result");
    u_host.run(100, n);
    u_host.read(1'b0, d, on, off);
    chk(d, 16'h1234, "new result");
    $display("hold test done");
    // select raised mid-conversion does not abort; sampling waits for its fall
    u_host.start();
    u_host.run(20, n);
    u_host.pins(1'b1, 1'b1);
    u_host.run(100, n2);
    chk(16'(n + n2), 16'(CONV_CYC), "busy with select high");
    chk({15'h0000, track}, 16'h0000, "no sampling while deselected");
    u_host.strobe();
    u_host.run(20, n);
    chk(16'(n), 16'h0000, "strobe ignored when deselected");
    u_host.pins(1'b0, 1'b1);
    u_host.run(5, n);
    chk({15'h0000, track}, 16'h0001, "sampling on select fall");
    $display("select test done");
    // k=0 strobe abort, k=1 select abort, k=2 reset pin with select high
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk_in) sample_code_in <= 16'h5A5A;
      u_host.start();
      u_host.run(100, n);
      u_host.start();
      u_host.run(20, n);
      if (k == 0) begin
        u_host.strobe();
      end else begin
        u_host.pins(1'b1, k[0]);
      end
      u_host.run(4, n);
      u_host.pins(1'b0, 1'b1);
      u_host.run(100, n2);
      chk(16'(n2 < 8), 16'h0001, "abort ends busy");
      u_host.read(1'b0, d, on, off);
      chk(d, 16'h0000, "result cleared");
      $display("abort kind %0d done", k);
    end
    // system reset during a conversion drops busy and the held word at once
    u_host.start();
    u_host.run(20, n);
    reset_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    #1 chk({15'h0000, busy}, 16'h0000, "busy after mid-run reset");
    u_host.run(100, n);
    chk(16'(n), 16'h0000, "no conversion after mid-run reset");
    u_host.read(1'b0, d, on, off);
    chk(d, 16'h0000, "word after mid-run reset");
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule // sar_adc_parallel_readout_tb
